// file: logic/reset_source_pkg.sv
// reset-source control constants: register map, codes, timing counts
// assumes a 100 MHz system clock and a plain strobe register port
// What this block does
// - guard register not holding either no-op pattern resets chip after delay
// - guard register loads 01010101B at power-on
// - corrupted guard register reset sets cause flag bit 3
// - all resets restore guard register except sleep/idle watchdog warm reset
// - guard cause flag never cleared by hardware, only by software writing 0
// - upper four cause flag bits read as zero
// - brown-out detection active when threshold valid, off in sleep and idle
// - low-supply indication acts only after persisting past qualify time
// - qualified brown-out resets, keeps threshold, sets flag bit 2
// - threshold codes 66,55,33,99,AA select voltages, F0 disables
// - undefined threshold code resets after delay and restores power-on value
// - undefined threshold reset sets flag bit 1, cleared only by software
// - threshold register loads 01100110B at power-on
// - writing 55H to second flash control register resets whole chip
// - run-mode watchdog time-out is full reset plus expiry flag set
// - sleep/idle time-out clears pc and sp, sets expiry and powerdown flags
// - watchdog-control reset sets flag bit 0, cleared only by software
package reset_source_pkg;
  localparam logic [1:0] ADDR_GUARD     = 2'h0;
  localparam logic [1:0] ADDR_CAUSE     = 2'h1;
  localparam logic [1:0] ADDR_THRESHOLD = 2'h2;
  localparam logic [1:0] ADDR_FLASH_CTRL_SECOND = 2'h3;
  localparam logic [7:0] GUARD_NOP_A    = 8'h55;
  localparam logic [7:0] GUARD_NOP_B    = 8'hAA;
  localparam logic [7:0] GUARD_POR      = 8'h55;
  localparam logic [7:0] THR_1V7        = 8'h66;
  localparam logic [7:0] THR_1V9        = 8'h55;
  localparam logic [7:0] THR_2V55       = 8'h33;
  localparam logic [7:0] THR_3V15       = 8'h99;
  localparam logic [7:0] THR_3V8        = 8'hAA;
  localparam logic [7:0] THR_DISABLE    = 8'hF0;
  localparam logic [7:0] THR_POR        = 8'h66;
  localparam logic [7:0] FLASH_RESET_KEY = 8'h55;
  localparam int FLAG_WDCTRL    = 0;
  localparam int FLAG_THRESHOLD = 1;
  localparam int FLAG_BROWNOUT  = 2;
  localparam int FLAG_GUARD     = 3;
  localparam logic [3:0] FLAGS_POR = 4'h0;
  localparam int CLK_PERIOD_NS  = 10;
  localparam int SOFT_RESET_DELAY_NS = 1000;
  localparam int BROWNOUT_QUALIFY_NS = 120;
  localparam int SOFT_RESET_CYCLES =
    (SOFT_RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BROWNOUT_QUALIFY_CYCLES =
    (BROWNOUT_QUALIFY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_PULSE_CYCLES = 4;
  typedef enum logic [2:0] {
    THR_SEL_NONE, THR_SEL_1V7, THR_SEL_1V9, THR_SEL_2V55,
    THR_SEL_3V15, THR_SEL_3V8
  } threshold_sel_e;
endpackage

// file: logic/persist_filter.sv
// qualifies a synchronised level that must hold for a number of cycles
// assumes input already sampled into the clock domain
`timescale 1ns/1ps
module persist_filter
  import reset_source_pkg::*;
#(
  parameter int COUNT = 4
) (
  input  wire logic mclk_in,
  input  wire logic reset_n_in,
  input  wire logic enable_in,
  input  wire logic level_in,
  output logic      qualified_out
);
  logic [15:0] count;
  logic [15:0] next_count;
  logic        next_qualified;

  // counts consecutive cycles of the level, restarts on any drop
  always_comb begin
    next_count = count;
    next_qualified = 1'b0;
    if (!enable_in || !level_in) begin
      next_count = 16'h0000;
    end else if (count >= 16'(COUNT)) begin
      next_qualified = 1'b1;
    end else begin
      next_count = count + 16'h0001;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      count <= 16'h0000;
      qualified_out <= 1'b0;
    end else begin
      count <= next_count;
      qualified_out <= next_qualified;
    end
  end

  a_short_dip_ignored: assert property (@(posedge mclk_in)
    disable iff (!reset_n_in)
    $rose(qualified_out) |-> $past(level_in, 1) && $past(level_in, COUNT))
    else $error("qualified without persisting level");
endmodule

// file: logic/delay_timer.sv
// one-shot delay counter: start pulse, done pulse COUNT+1 cycles after start
// assumes start is a same-domain pulse
`timescale 1ns/1ps
module delay_timer
  import reset_source_pkg::*;
#(
  parameter int COUNT = 8
) (
  input  wire logic mclk_in,
  input  wire logic reset_n_in,
  input  wire logic start_in,
  output logic      done_out
);
  logic [15:0] remain;
  logic [15:0] next_remain;
  logic        next_done;

  // loads on start, counts down, pulses done at one
  always_comb begin
    next_remain = remain;
    next_done = 1'b0;
    if (remain == 16'h0000) begin
      if (start_in) begin
        next_remain = 16'(COUNT);
      end
    end else begin
      next_remain = remain - 16'h0001;
      next_done = (remain == 16'h0001);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      remain <= 16'h0000;
      done_out <= 1'b0;
    end else begin
      remain <= next_remain;
      done_out <= next_done;
    end
  end
endmodule

// file: logic/reset_source_control.sv
// reset-source control: guard, brown-out, flash key and watchdog resets
// assumes a single system clock; supply monitor input is asynchronous
`timescale 1ns/1ps
module reset_source_control
  import reset_source_pkg::*;
(
  input  wire logic       mclk_in,
  input  wire logic       reset_n_in,
  input  wire logic [1:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       write_in,
  input  wire logic       read_in,
  output logic [7:0]      rdata_out,
  input  wire logic       low_supply_in,
  input  wire logic       sleep_idle_in,
  input  wire logic       watchdog_timeout_in,
  input  wire logic       watchdog_ctrl_bad_in,
  output logic            chip_reset_out,
  output logic            pc_sp_clear_out,
  output logic            watchdog_expiry_flag_set_out,
  output logic            powerdown_flag_set_out,
  output logic            brownout_active_out,
  output logic [2:0]      threshold_select_out
);
  // longest wait from a corrupt guard word to the chip reset
  localparam int GUARD_RESET_WINDOW = SOFT_RESET_CYCLES + 3;

  logic [7:0] guard_register;
  logic [7:0] next_guard_register;
  logic [7:0] threshold_register;
  logic [7:0] next_threshold_register;
  logic [3:0] cause_flags;
  logic [3:0] next_cause_flags;
  logic [7:0] next_rdata;
  logic       supply_meta;
  logic       supply_sync;
  logic       guard_bad;
  logic       thr_bad;
  logic       guard_pending;
  logic       next_guard_pending;
  logic       thr_pending;
  logic       next_thr_pending;
  logic       wd_pending;
  logic       next_wd_pending;
  logic       bad_seen;
  logic       next_bad_seen;
  logic       soft_start;
  logic       soft_done;
  logic       brownout_qualified;
  logic       flash_key_hit;
  logic       run_timeout;
  logic       warm_timeout;
  logic       full_reset;
  logic [2:0] pulse_count;
  logic [2:0] next_pulse_count;
  logic       next_pc_sp_clear;
  logic       next_expiry_set;
  logic       next_powerdown_set;
  threshold_sel_e thr_sel;

  // two-stage sampling of the asynchronous supply monitor
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      supply_meta <= 1'b0;
      supply_sync <= 1'b0;
    end else begin
      supply_meta <= low_supply_in;
      supply_sync <= supply_meta;
    end
  end

  // threshold decode
  always_comb begin
    thr_bad = 1'b0;
    unique case (threshold_register)
      THR_1V7:     thr_sel = THR_SEL_1V7;
      THR_1V9:     thr_sel = THR_SEL_1V9;
      THR_2V55:    thr_sel = THR_SEL_2V55;
      THR_3V15:    thr_sel = THR_SEL_3V15;
      THR_3V8:     thr_sel = THR_SEL_3V8;
      THR_DISABLE: thr_sel = THR_SEL_NONE;
      default: begin
        thr_sel = THR_SEL_NONE;
        thr_bad = 1'b1;
      end
    endcase
  end

  assign guard_bad = (guard_register != GUARD_NOP_A)
                  && (guard_register != GUARD_NOP_B);
  // detection off in sleep and idle, or when disabled
  assign brownout_active_out = (thr_sel != THR_SEL_NONE)
                            && !sleep_idle_in;
  assign threshold_select_out = thr_sel;
  assign flash_key_hit = write_in && (addr_in == ADDR_FLASH_CTRL_SECOND)
                      && (wdata_in == FLASH_RESET_KEY);
  assign run_timeout = watchdog_timeout_in && !sleep_idle_in;
  assign warm_timeout = watchdog_timeout_in && sleep_idle_in;

  persist_filter #(
    .COUNT (BROWNOUT_QUALIFY_CYCLES)
  ) u_brownout_filter (
    .mclk_in       (mclk_in),
    .reset_n_in    (reset_n_in),
    .enable_in     (brownout_active_out),
    .level_in      (supply_sync),
    .qualified_out (brownout_qualified)
  );

  // start the delay on first detection of any corruption; held off
  // while a chip reset runs, so a cause that is still being cleared
  // by that reset is not counted a second time
  assign soft_start = (guard_bad || thr_bad || watchdog_ctrl_bad_in)
                   && !bad_seen && !full_reset && !chip_reset_out;

  delay_timer #(
    .COUNT (SOFT_RESET_CYCLES)
  ) u_soft_delay (
    .mclk_in    (mclk_in),
    .reset_n_in (reset_n_in),
    .start_in   (soft_start),
    .done_out   (soft_done)
  );

  assign full_reset = soft_done || brownout_qualified || flash_key_hit
                   || run_timeout;

  // register, cause and sequencing next-state logic
  always_comb begin
    next_guard_register = guard_register;
    next_threshold_register = threshold_register;
    next_cause_flags = cause_flags;
    next_guard_pending = guard_pending || (soft_start && guard_bad);
    next_thr_pending = thr_pending || (soft_start && thr_bad);
    next_wd_pending = wd_pending || (soft_start && watchdog_ctrl_bad_in);
    next_bad_seen = bad_seen || soft_start;
    next_pulse_count = (pulse_count != 3'h0) ? pulse_count - 3'h1 : 3'h0;
    next_pc_sp_clear = warm_timeout;
    next_expiry_set = watchdog_timeout_in;
    next_powerdown_set = warm_timeout;
    next_rdata = 8'h00;
    if (read_in) begin
      unique case (addr_in)
        ADDR_GUARD:     next_rdata = guard_register;
        ADDR_CAUSE:     next_rdata = {4'h0, cause_flags};
        ADDR_THRESHOLD: next_rdata = threshold_register;
        default:        next_rdata = 8'h00;
      endcase
    end
    // software may only clear flags by writing zero
    if (write_in && addr_in == ADDR_CAUSE) begin
      next_cause_flags = cause_flags & wdata_in[3:0];
    end
    if (write_in && addr_in == ADDR_GUARD) begin
      next_guard_register = wdata_in;
    end
    if (write_in && addr_in == ADDR_THRESHOLD) begin
      next_threshold_register = wdata_in;
    end
    if (full_reset) begin
      next_guard_register = GUARD_POR;
      next_pulse_count = 3'(RESET_PULSE_CYCLES);
      next_bad_seen = 1'b0;
      next_guard_pending = 1'b0;
      next_thr_pending = 1'b0;
      next_wd_pending = 1'b0;
      // flags set last so an event beats a software clear
      if (soft_done && guard_pending) begin
        next_cause_flags[FLAG_GUARD] = 1'b1;
      end
      if (soft_done && thr_pending) begin
        next_cause_flags[FLAG_THRESHOLD] = 1'b1;
        next_threshold_register = THR_POR;
      end
      if (soft_done && wd_pending) begin
        next_cause_flags[FLAG_WDCTRL] = 1'b1;
      end
      if (brownout_qualified) begin
        next_cause_flags[FLAG_BROWNOUT] = 1'b1;
      end
    end
  end

  // state registers; power-on values on reset
  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      guard_register <= GUARD_POR;
      threshold_register <= THR_POR;
      cause_flags <= FLAGS_POR;
      guard_pending <= 1'b0;
      thr_pending <= 1'b0;
      wd_pending <= 1'b0;
      bad_seen <= 1'b0;
      pulse_count <= 3'h0;
      rdata_out <= 8'h00;
      pc_sp_clear_out <= 1'b0;
      watchdog_expiry_flag_set_out <= 1'b0;
      powerdown_flag_set_out <= 1'b0;
    end else begin
      guard_register <= next_guard_register;
      threshold_register <= next_threshold_register;
      cause_flags <= next_cause_flags;
      guard_pending <= next_guard_pending;
      thr_pending <= next_thr_pending;
      wd_pending <= next_wd_pending;
      bad_seen <= next_bad_seen;
      pulse_count <= next_pulse_count;
      rdata_out <= next_rdata;
      pc_sp_clear_out <= next_pc_sp_clear;
      watchdog_expiry_flag_set_out <= next_expiry_set;
      powerdown_flag_set_out <= next_powerdown_set;
    end
  end

  // chip reset stands while the pulse counter runs
  assign chip_reset_out = (pulse_count != 3'h0);

  // a corrupt guard word must reach the chip reset within the delay plus three cycles
  a_guard_bad_resets: assert property (@(posedge mclk_in)
    disable iff (!reset_n_in)
    (guard_bad && !bad_seen && !full_reset && !chip_reset_out)
      |-> ##[1:GUARD_RESET_WINDOW] chip_reset_out)
    else $error("corrupt guard did not reset");

  // power-on value of the guard register
  a_guard_por: assert property (@(posedge mclk_in)
    !reset_n_in |=> guard_register == GUARD_POR)
    else $error("guard not at power-on value");

  // guard cause flag set by its own delayed reset
  a_guard_flag_set: assert property (@(posedge mclk_in)
    disable iff (!reset_n_in)
    (soft_done && guard_pending) |=> cause_flags[FLAG_GUARD])
    else $error("guard cause flag not set");

  // every full reset restores the guard register
  a_guard_restored: assert property (@(posedge mclk_in)
    disable iff (!reset_n_in)
    full_reset |=> guard_register == GUARD_POR)
    else $error("guard not restored on reset");

  // only a software write may clear the guard cause flag
  a_flags_sticky: assert property (@(posedge mclk_in)
    disable iff (!reset_n_in)
    (cause_flags[FLAG_GUARD] && !(write_in && addr_in == ADDR_CAUSE))
      |=> cause_flags[FLAG_GUARD])
    else $error("guard flag cleared by hardware");

  // unimplemented cause bits read as zero
  a_upper_zero: assert property (@(posedge mclk_in)
    disable iff (!reset_n_in)
    (read_in && addr_in == ADDR_CAUSE) |=> rdata_out[7:4] == 4'h0)
    else $error("upper cause bits not zero");

  // detection is off in sleep and idle
  a_sleep_no_bo: assert property (@(posedge mclk_in)
    disable iff (!reset_n_in)
    sleep_idle_in |-> !brownout_active_out)
    else $error("brown-out active in sleep");

  // an inactive detector never qualifies a low supply
  a_bo_off_quiet: assert property (@(posedge mclk_in)
    disable iff (!reset_n_in)
    !brownout_active_out |=> !brownout_qualified)
    else $error("brown-out qualified while inactive");

  // brown-out sets its flag and keeps the threshold
  a_brownout_flag: assert property (@(posedge mclk_in)
    disable iff (!reset_n_in)
    brownout_qualified |=> cause_flags[FLAG_BROWNOUT]
      && threshold_register == $past(threshold_register))
    else $error("brown-out flag or threshold wrong");

  // undefined threshold restores power-on value and sets its flag
  a_thr_restore: assert property (@(posedge mclk_in)
    disable iff (!reset_n_in)
    (soft_done && thr_pending) |=> threshold_register == THR_POR
      && cause_flags[FLAG_THRESHOLD])
    else $error("threshold not restored");

  // power-on value of the threshold register
  a_thr_por: assert property (@(posedge mclk_in)
    !reset_n_in |=> threshold_register == THR_POR)
    else $error("threshold not at power-on value");

  // flash key write gives a full-length chip reset
  a_flash_key: assert property (@(posedge mclk_in)
    disable iff (!reset_n_in)
    flash_key_hit |=> chip_reset_out [*4])
    else $error("flash key did not reset");

  // run-mode time-out: full reset and expiry pulse, no warm clear
  a_run_timeout: assert property (@(posedge mclk_in)
    disable iff (!reset_n_in)
    run_timeout |=> chip_reset_out && watchdog_expiry_flag_set_out
      && !pc_sp_clear_out && !powerdown_flag_set_out)
    else $error("run timeout wrong");

  // sleep time-out clears pc and sp only, guard untouched
  a_warm_timeout: assert property (@(posedge mclk_in)
    disable iff (!reset_n_in)
    (warm_timeout && !full_reset && !write_in)
      |=> pc_sp_clear_out && powerdown_flag_set_out
      && guard_register == $past(guard_register))
    else $error("warm timeout wrong");

  // watchdog control corruption sets its flag
  a_wdctrl_flag: assert property (@(posedge mclk_in)
    disable iff (!reset_n_in)
    (soft_done && wd_pending) |=> cause_flags[FLAG_WDCTRL])
    else $error("watchdog control flag not set");
endmodule

// file: test/reset_source_control_tb.sv
// self-checking bench for the reset-source control block
// assumes the package constants and the design's 100 MHz single clock
`timescale 1ns/1ps
module reset_source_control_tb;
  import reset_source_pkg::*;
  logic       mclk_in;
  logic       reset_n_in;
  logic [1:0] addr_in;
  logic [7:0] wdata_in;
  logic       write_in;
  logic       read_in;
  logic [7:0] rdata_out;
  logic       low_supply_in;
  logic       sleep_idle_in;
  logic       watchdog_timeout_in;
  logic       watchdog_ctrl_bad_in;
  logic       chip_reset_out;
  logic       pc_sp_clear_out;
  logic       watchdog_expiry_flag_set_out;
  logic       powerdown_flag_set_out;
  logic       brownout_active_out;
  logic [2:0] threshold_select_out;
  int         fail_count;
  int         checks_done;
  logic [7:0] d;
  int         n;

  reset_source_control uut (
    .mclk_in(mclk_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .write_in(write_in), .read_in(read_in),
    .rdata_out(rdata_out), .low_supply_in(low_supply_in),
    .sleep_idle_in(sleep_idle_in),
    .watchdog_timeout_in(watchdog_timeout_in),
    .watchdog_ctrl_bad_in(watchdog_ctrl_bad_in),
    .chip_reset_out(chip_reset_out), .pc_sp_clear_out(pc_sp_clear_out),
    .watchdog_expiry_flag_set_out(watchdog_expiry_flag_set_out),
    .powerdown_flag_set_out(powerdown_flag_set_out),
    .brownout_active_out(brownout_active_out),
    .threshold_select_out(threshold_select_out)
  );

  // free-running system clock
  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string m);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // one-cycle bus strobes, changed right after a rising edge
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge mclk_in);
    addr_in  <= a;
    wdata_in <= v;
    write_in <= 1'b1;
    @(posedge mclk_in);
    write_in <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge mclk_in);
    addr_in <= a;
    read_in <= 1'b1;
    @(posedge mclk_in);
    read_in <= 1'b0;
    @(posedge mclk_in);
    v = rdata_out;
  endtask

  // bounded wait for a full reset pulse, then for its end
  task automatic wait_rst(input int lim, output int cnt);
    int k;
    cnt = 0;
    k = 0;
    while (chip_reset_out !== 1'b1) begin
      if (cnt >= lim) begin
        chk(8'h01, 8'h00, "reset never came");
        report_and_stop();
      end
      @(posedge mclk_in);
      cnt++;
    end
    low_supply_in        <= 1'b0;
    watchdog_ctrl_bad_in <= 1'b0;
    while (chip_reset_out !== 1'b0) begin
      if (k >= 10) begin
        chk(8'h01, 8'h00, "reset never ended");
        report_and_stop();
      end
      @(posedge mclk_in);
      k++;
    end
  endtask

  task automatic quiet(input int c);
    repeat (c) begin
      @(posedge mclk_in);
      chk({7'h00, chip_reset_out}, 8'h00, "unexpected reset");
    end
  endtask

  task automatic t_por();
    rd(ADDR_GUARD, d);
    chk(d, 8'h55, "guard por");
    rd(ADDR_CAUSE, d);
    chk(d, 8'h00, "cause por");
    rd(ADDR_THRESHOLD, d);
    chk(d, 8'h66, "threshold por");
    rd(ADDR_FLASH_CTRL_SECOND, d);
    chk(d, 8'h00, "unmapped read");
    chk({5'h00, threshold_select_out}, 8'h01, "por select");
  endtask

  task automatic t_decode();
    logic [7:0] codes [6];
    codes = '{8'h66, 8'h55, 8'h33, 8'h99, 8'hAA, 8'hF0};
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_THRESHOLD, codes[i]);
      @(posedge mclk_in);
      #1;
      chk({5'h00, threshold_select_out}, 8'((i + 1) % 6), "select");
      chk({7'h00, brownout_active_out}, {7'h00, i < 5}, "active");
    end
    wr(ADDR_THRESHOLD, 8'h66);
    @(posedge mclk_in);
    sleep_idle_in <= 1'b1;
    @(posedge mclk_in);
    #1;
    chk({7'h00, brownout_active_out}, 8'h00, "sleep active");
    @(posedge mclk_in);
    sleep_idle_in <= 1'b0;
  endtask

  task automatic t_guard();
    wr(ADDR_GUARD, 8'hAA);
    quiet(SOFT_RESET_CYCLES + 10);
    wr(ADDR_GUARD, 8'h12);
    wait_rst(SOFT_RESET_CYCLES + 10, n);
    chk({7'h00, n >= SOFT_RESET_CYCLES}, 8'h01, "delay short");
    rd(ADDR_GUARD, d);
    chk(d, 8'h55, "guard restored");
    rd(ADDR_CAUSE, d);
    chk(d, 8'h08, "guard flag");
    wr(ADDR_CAUSE, 8'h00);
    rd(ADDR_CAUSE, d);
    chk(d, 8'h00, "guard flag clear");
  endtask

  task automatic t_thr();
    wr(ADDR_THRESHOLD, 8'h12);
    wait_rst(SOFT_RESET_CYCLES + 10, n);
    chk({7'h00, n >= SOFT_RESET_CYCLES}, 8'h01, "delay short");
    rd(ADDR_THRESHOLD, d);
    chk(d, 8'h66, "threshold restored");
    rd(ADDR_CAUSE, d);
    chk(d, 8'h02, "threshold flag");
    wr(ADDR_CAUSE, 8'h00);
  endtask

  task automatic t_flash();
    wr(ADDR_GUARD, 8'hAA);
    wr(ADDR_FLASH_CTRL_SECOND, 8'hAA);
    quiet(5);
    wr(ADDR_FLASH_CTRL_SECOND, FLASH_RESET_KEY);
    wait_rst(6, n);
    rd(ADDR_GUARD, d);
    chk(d, 8'h55, "guard after key");
  endtask

  task automatic t_brown();
    wr(ADDR_THRESHOLD, 8'h33);
    @(posedge mclk_in);
    low_supply_in <= 1'b1;
    repeat (8) @(posedge mclk_in);
    low_supply_in <= 1'b0;
    quiet(30);
    @(posedge mclk_in);
    low_supply_in <= 1'b1;
    wait_rst(BROWNOUT_QUALIFY_CYCLES + 8, n);
    chk({7'h00, n > BROWNOUT_QUALIFY_CYCLES}, 8'h01, "qualify");
    rd(ADDR_THRESHOLD, d);
    chk(d, 8'h33, "threshold kept");
    rd(ADDR_CAUSE, d);
    chk(d, 8'h04, "brownout flag");
    wr(ADDR_CAUSE, 8'h00);
  endtask

  task automatic t_wd_run();
    @(posedge mclk_in);
    watchdog_timeout_in <= 1'b1;
    @(posedge mclk_in);
    watchdog_timeout_in <= 1'b0;
    #1;
    chk({7'h00, chip_reset_out}, 8'h01, "run reset");
    chk({7'h00, watchdog_expiry_flag_set_out}, 8'h01, "run exp");
    chk({7'h00, pc_sp_clear_out}, 8'h00, "run pcsp");
    chk({7'h00, powerdown_flag_set_out}, 8'h00, "run pdf");
    wait_rst(2, n);
  endtask

  task automatic t_wd_sleep();
    wr(ADDR_GUARD, 8'hAA);
    @(posedge mclk_in);
    sleep_idle_in       <= 1'b1;
    watchdog_timeout_in <= 1'b1;
    @(posedge mclk_in);
    watchdog_timeout_in <= 1'b0;
    #1;
    chk({7'h00, pc_sp_clear_out}, 8'h01, "pcsp");
    chk({7'h00, powerdown_flag_set_out}, 8'h01, "pdf");
    chk({7'h00, watchdog_expiry_flag_set_out}, 8'h01, "exp");
    quiet(10);
    sleep_idle_in <= 1'b0;
    rd(ADDR_GUARD, d);
    chk(d, 8'hAA, "guard kept");
  endtask

  task automatic t_wd_ctrl();
    @(posedge mclk_in);
    watchdog_ctrl_bad_in <= 1'b1;
    wait_rst(SOFT_RESET_CYCLES + 10, n);
    rd(ADDR_CAUSE, d);
    chk(d, 8'h01, "wdctrl flag");
    wr(ADDR_CAUSE, 8'h00);
    rd(ADDR_CAUSE, d);
    chk(d, 8'h00, "wdctrl clear");
    quiet(SOFT_RESET_CYCLES + 10);
  endtask

  // reset, then every scenario in turn
  initial begin
    fail_count           = 0;
    checks_done          = 0;
    reset_n_in           = 1'b0;
    addr_in              = 2'h0;
    wdata_in             = 8'h00;
    write_in             = 1'b0;
    read_in              = 1'b0;
    low_supply_in        = 1'b0;
    sleep_idle_in        = 1'b0;
    watchdog_timeout_in  = 1'b0;
    watchdog_ctrl_bad_in = 1'b0;
    repeat (3) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    t_por();
    t_decode();
    t_guard();
    t_thr();
    t_flash();
    t_brown();
    t_wd_run();
    t_wd_sleep();
    t_wd_ctrl();
    report_and_stop();
  end
endmodule
